// *** design/ssfl_log_compare.sv ***
`timescale 1ns/10ps
module ssfl_log_compare #(
   parameter int W = 7
) (
   // monitored functions
   input wire logic [W-1:0] live,
   input wire logic [W-1:0] mask,
   input wire logic [W-1:0] snap,
   // results
   output logic [W-1:0] masked,
   output logic changed
);
   logic [W-1:0] diff;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         // masked bits log as zero and never count as a change
         assign masked[i] = live[i] & ~mask[i];
         assign diff[i] = (live[i] ^ snap[i]) & ~mask[i];
      end
   endgenerate

   assign changed = |diff;
endmodule

// *** design/ssfl_regs.sv ***
`timescale 1ns/10ps
module ssfl_regs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // monitored functions
   input wire logic [ssfl_pkg::SUPPLY_COUNT-1:0] supplyFault,
   input wire logic [ssfl_pkg::GENERAL_COUNT-1:0] generalInput,
   input wire logic watchdogTimeout,
   input wire logic [ssfl_pkg::OUTPUT_COUNT-1:0] programmableOutput,
   // register port behind the two-wire command decoder
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic regRead,
   output logic [7:0] regRdData,
   output logic regRdValid
);
   import ssfl_pkg::*;

   ssfl_state_t s;
   ssfl_state_t next_s;
   logic readClear;
   logic [SUPPLY_COUNT-1:0] supCmpSnap;
   logic [INPUT_COUNT-1:0] inCmpSnap;
   logic [SUPPLY_COUNT-1:0] supMasked;
   logic [INPUT_COUNT-1:0] inMasked;
   logic supChanged;
   logic inChanged;
   logic anyChange;

   assign readClear = regRead && (regAddr == ADDR_INPUT_FAULT_LOG);
   // an input fault log read rearms against both log values held in the same cycle
   assign supCmpSnap = readClear ? s.supLog : s.supSnap;
   assign inCmpSnap = readClear ? s.inLog : s.inSnap;

   ssfl_log_compare #(
      .W(SUPPLY_COUNT)
   ) u_sup_cmp (
      .live(s.detStat),
      .mask(s.supMask),
      .snap(supCmpSnap),
      .masked(supMasked),
      .changed(supChanged)
   );

   ssfl_log_compare #(
      .W(INPUT_COUNT)
   ) u_in_cmp (
      .live(s.inStat),
      .mask(s.inMask),
      .snap(inCmpSnap),
      .masked(inMasked),
      .changed(inChanged)
   );

   assign anyChange = supChanged | inChanged;

   always_comb
   begin
      next_s = s;
      // live status sampling
      next_s.detStat = supplyFault;
      next_s.inStat = {watchdogTimeout, generalInput};
      next_s.outStat = programmableOutput;
      // change log: follows while armed, holds once flagged except that masked bits clear
      if (!s.flag || readClear)
      begin
         next_s.supLog = supMasked;
         next_s.inLog = inMasked;
      end
      else
      begin
         next_s.supLog = s.supLog & ~s.supMask;
         next_s.inLog = s.inLog & ~s.inMask;
      end
      if (readClear)
      begin
         next_s.supSnap = s.supLog;
         next_s.inSnap = s.inLog;
      end
      // a change in the read cycle wins over the clear
      if (anyChange && (!s.flag || readClear))
         next_s.flag = 1'b1;
      else if (readClear)
         next_s.flag = 1'b0;
      // host writes to the masks
      if (regWrite && regAddr == ADDR_SUPPLY_FAULT_MASK)
         next_s.supMask = regWrData[SUPPLY_COUNT-1:0];
      if (regWrite && regAddr == ADDR_INPUT_FAULT_MASK)
         next_s.inMask = regWrData[INPUT_COUNT-1:0];
      // read answer
      next_s.rdValid = regRead;
      next_s.rdData = READ_NONE;
      if (regRead)
      begin
         unique case (regAddr)
            ADDR_SUPPLY_FAULT_MASK: next_s.rdData = {1'b0, s.supMask};
            ADDR_INPUT_FAULT_MASK: next_s.rdData = {3'h0, s.inMask};
            ADDR_DETECTOR_LIVE_STATUS: next_s.rdData = {1'b0, s.detStat};
            ADDR_INPUT_LIVE_STATUS: next_s.rdData = {3'h0, s.inStat};
            ADDR_SUPPLY_FAULT_LOG: next_s.rdData = {s.flag, s.supLog};
            ADDR_INPUT_FAULT_LOG: next_s.rdData = {3'h0, s.inLog};
            ADDR_OUTPUT_STATUS_LOW: next_s.rdData = s.outStat[7:0];
            ADDR_OUTPUT_STATUS_HIGH: next_s.rdData = {7'h00, s.outStat[8]};
            default: next_s.rdData = READ_NONE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         s <= '0;
      else
         s <= next_s;
   end

   assign regRdData = s.rdData;
   assign regRdValid = s.rdValid;

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_det_status_read: assert property (
      regRead && regAddr == ADDR_DETECTOR_LIVE_STATUS && !$past(reset)
      |=> regRdData == {1'b0, $past(supplyFault, 2)})
      else $error("detector status read wrong");
   a_wdog_status_read: assert property (
      regRead && regAddr == ADDR_INPUT_LIVE_STATUS && !$past(reset)
      |=> regRdData[WATCHDOG_BIT] == $past(watchdogTimeout, 2))
      else $error("watchdog status bit wrong");
   a_gpi_status_read: assert property (
      regRead && regAddr == ADDR_INPUT_LIVE_STATUS && !$past(reset)
      |=> regRdData[3:0] == $past(generalInput, 2) && regRdData[7:5] == 3'h0)
      else $error("general input status wrong");
   a_out_low_read: assert property (
      regRead && regAddr == ADDR_OUTPUT_STATUS_LOW && !$past(reset)
      |=> regRdData == $past(programmableOutput[7:0], 2))
      else $error("low output status wrong");
   a_out_high_read: assert property (
      regRead && regAddr == ADDR_OUTPUT_STATUS_HIGH && !$past(reset)
      |=> regRdData == {7'h00, $past(programmableOutput[8], 2)})
      else $error("high output status wrong");
   a_flag_on_change: assert property (
      !s.flag && anyChange |=> s.flag && regRdValid == $past(regRead))
      else $error("summary flag missed a change");
   a_sup_log_track: assert property (
      !s.flag |=> s.supLog == ($past(s.detStat) & ~$past(s.supMask)))
      else $error("supply log not tracking");
   a_in_log_track: assert property (
      !s.flag |=> s.inLog == ($past(s.inStat) & ~$past(s.inMask)))
      else $error("input log not tracking");
   a_sup_mask_zero: assert property (
      ##1 (s.supLog & $past(s.supMask)) == '0)
      else $error("masked supply logged");
   a_in_mask_zero: assert property (
      ##1 (s.inLog & $past(s.inMask)) == '0)
      else $error("masked input logged");
   a_reset_clear: assert property (
      @(posedge ref_clk) $fell(reset) |-> s.flag == 1'b0 && s.supMask == '0
      && s.supLog == '0 && s.inLog == '0 && regRdData == REG_RESET)
      else $error("state not zero after reset");
   a_log_frozen: assert property (
      s.flag && !readClear && next_s.supMask == s.supMask && next_s.inMask == s.inMask
      |=> $stable(s.supLog) && $stable(s.inLog) && s.flag)
      else $error("log moved while frozen");
   a_read_clears: assert property (
      s.flag && readClear && !anyChange ##1 !anyChange |-> !s.flag ##1 !s.flag)
      else $error("read did not clear summary");
   a_masked_quiet: assert property (
      !s.flag && !readClear && ((s.detStat ^ s.supSnap) & ~s.supMask) == '0
      && ((s.inStat ^ s.inSnap) & ~s.inMask) == '0 |=> !s.flag)
      else $error("masked change set summary");

   c_supply_fault: cover property (!s.flag ##1 s.flag && s.supLog != '0);
   c_read_rearm: cover property (s.flag && readClear ##1 !s.flag);
   c_set_beats_clear: cover property (s.flag && readClear && anyChange ##1 s.flag);
   c_mask_write: cover property (regWrite && regAddr == ADDR_INPUT_FAULT_MASK);
endmodule

// *** dv/ssfl_host_model.sv ***
`timescale 1ns/10ps
module ssfl_host_model (
   // clock
   input wire logic ref_clk,
   // register port
   output logic [7:0] regAddr,
   output logic regWrite,
   output logic [7:0] regWrData,
   output logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   initial
   begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regWrData = 8'h00;
      regRead = 1'b0;
   end
   // one write strobe, then released lines show the inverse
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask
   // one read strobe, answer taken at the edge where valid is sampled high
   // input fault log is read only after the summary flag was seen high
   task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      @(posedge ref_clk);
      d = regRdData;
      v = regRdValid;
   endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
   import ssfl_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [SUPPLY_COUNT-1:0] supplyFault = '0;
   logic [GENERAL_COUNT-1:0] generalInput = '0;
   logic watchdogTimeout = 1'b0;
   logic [OUTPUT_COUNT-1:0] programmableOutput = '0;
   logic [7:0] regAddr, regWrData, regRdData;
   logic regWrite, regRead, regRdValid;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   ssfl_regs dut_u (.ref_clk(ref_clk), .reset(reset), .supplyFault(supplyFault),
      .generalInput(generalInput), .watchdogTimeout(watchdogTimeout),
      .programmableOutput(programmableOutput), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .regRdValid(regRdValid));
   ssfl_host_model host_u (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .regRdValid(regRdValid));
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // read and compare, valid pulse included
   task rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host_u.rd(a, d, v);
      `CHK("valid", 1'b1, v)
      `CHK("rdata", e, d)
   endtask
   task settle;
      repeat (3) @(posedge ref_clk);
   endtask
   task t_reset;
      rchk(ADDR_SUPPLY_FAULT_MASK, 8'h00);
      rchk(ADDR_INPUT_FAULT_MASK, 8'h00);
      rchk(ADDR_DETECTOR_LIVE_STATUS, 8'h00);
      rchk(ADDR_INPUT_LIVE_STATUS, 8'h00);
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'h00);
      rchk(ADDR_OUTPUT_STATUS_LOW, 8'h00);
      rchk(ADDR_OUTPUT_STATUS_HIGH, 8'h00);
      rchk(8'h00, 8'h00);
   endtask
   task t_live;
      supplyFault <= 7'h55;
      generalInput <= 4'hA;
      watchdogTimeout <= 1'b1;
      programmableOutput <= 9'h1A5;
      settle();
      rchk(ADDR_DETECTOR_LIVE_STATUS, 8'h55);
      rchk(ADDR_INPUT_LIVE_STATUS, 8'h1A);
      rchk(ADDR_OUTPUT_STATUS_LOW, 8'hA5);
      rchk(ADDR_OUTPUT_STATUS_HIGH, 8'h01);
   endtask
   task t_log;
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'hD5);
      rchk(ADDR_INPUT_FAULT_LOG, 8'h1A);
      supplyFault <= 7'h5D;
      settle();
      generalInput <= 4'h2;
      settle();
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'hDD);
      rchk(ADDR_INPUT_FAULT_LOG, 8'h1A);
      settle();
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'hDD);
      rchk(ADDR_INPUT_FAULT_LOG, 8'h12);
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'h5D);
   endtask
   task t_mask;
      host_u.wr(ADDR_SUPPLY_FAULT_MASK, 8'hFF);
      host_u.wr(ADDR_INPUT_FAULT_MASK, 8'hFF);
      rchk(ADDR_SUPPLY_FAULT_MASK, 8'h7F);
      rchk(ADDR_INPUT_FAULT_MASK, 8'h1F);
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'h00);
      supplyFault <= 7'h00;
      watchdogTimeout <= 1'b0;
      settle();
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'h00);
      host_u.wr(ADDR_SUPPLY_FAULT_MASK, 8'h00);
      host_u.wr(ADDR_INPUT_FAULT_MASK, 8'h00);
      settle();
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'h80);
      rchk(ADDR_INPUT_FAULT_LOG, 8'h00);
      rchk(ADDR_SUPPLY_FAULT_LOG, 8'h80);
      rchk(ADDR_INPUT_FAULT_LOG, 8'h02);
      host_u.wr(ADDR_DETECTOR_LIVE_STATUS, 8'hFF);
      rchk(ADDR_DETECTOR_LIVE_STATUS, 8'h00);
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_live();
      t_log();
      t_mask();
      tally_and_finish();
   end
endmodule

// *** inc/ssfl_pkg.sv ***
package ssfl_pkg;
   // register offsets
   localparam logic [7:0] ADDR_SUPPLY_FAULT_MASK = 8'h9D;
   localparam logic [7:0] ADDR_INPUT_FAULT_MASK = 8'h9E;
   localparam logic [7:0] ADDR_DETECTOR_LIVE_STATUS = 8'hDA;
   localparam logic [7:0] ADDR_INPUT_LIVE_STATUS = 8'hDB;
   localparam logic [7:0] ADDR_SUPPLY_FAULT_LOG = 8'hDC;
   localparam logic [7:0] ADDR_INPUT_FAULT_LOG = 8'hDD;
   localparam logic [7:0] ADDR_OUTPUT_STATUS_LOW = 8'hDE;
   localparam logic [7:0] ADDR_OUTPUT_STATUS_HIGH = 8'hDF;
   // widths and field positions
   localparam int SUPPLY_COUNT = 7;
   localparam int GENERAL_COUNT = 4;
   localparam int INPUT_COUNT = 5;
   localparam int OUTPUT_COUNT = 9;
   localparam int SUMMARY_BIT = 7;
   localparam int WATCHDOG_BIT = 4;
   // reset value of every register
   localparam logic [7:0] REG_RESET = 8'h00;
   // value read at reserved bits and unmapped offsets
   localparam logic [7:0] READ_NONE = 8'h00;

   typedef struct packed {
      logic [SUPPLY_COUNT-1:0] detStat;
      logic [INPUT_COUNT-1:0] inStat;
      logic [OUTPUT_COUNT-1:0] outStat;
      logic [SUPPLY_COUNT-1:0] supLog;
      logic [INPUT_COUNT-1:0] inLog;
      logic flag;
      logic [SUPPLY_COUNT-1:0] supSnap;
      logic [INPUT_COUNT-1:0] inSnap;
      logic [SUPPLY_COUNT-1:0] supMask;
      logic [INPUT_COUNT-1:0] inMask;
      logic [7:0] rdData;
      logic rdValid;
   } ssfl_state_t;
endpackage
